// [hdl/sio_map.vh]
// register map, field layout and pin assignment of the six-bit port
`ifndef SIO_MAP_VH
`define SIO_MAP_VH

// register indices; byte address is four times the index
`define SIO_IDX_PIN_DIRECTION  16'hfeb2
`define SIO_IDX_PIN_LEVEL      16'hff52
`define SIO_IDX_OUTPUT_LATCH   16'hff62
`define SIO_IDX_DRAIN_SELECT   16'hff76
`define SIO_IDX_W              16

// field layout and reset values
`define SIO_PORT_W             6
`define SIO_FIELD_MSB          5
`define SIO_REG_W              8
`define SIO_RESV_W             2
`define SIO_RST_PORT           6'h00
`define SIO_RESV_READ          2'h0
`define SIO_DIR_READ           8'h00

// bus answers
`define SIO_RESP_OKAY          2'h0
`define SIO_RESP_SLVERR        2'h2

// pin n carries these serial functions
`define SIO_PIN_TX0            0
`define SIO_PIN_TX1            1
`define SIO_PIN_RX0            2
`define SIO_PIN_RX1            3
`define SIO_PIN_CLK0           4
`define SIO_PIN_CLK1           5
`define SIO_CHANNELS           2

`endif

// [hdl/sio_sync.v]
// two flip-flop synchroniser for pin inputs
module sio_sync #(
   parameter W = 6
) (
   input  wire         clk,
   input  wire         reset,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_r;

   always @(posedge clk) begin
      if (reset) begin
         meta_r <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sio_sync

// [hdl/sio_pin_cell.v]
// output selection and drive stage of one port pin
module sio_pin_cell (
   input  wire clk,
   input  wire reset,
   input  wire clear,
   input  wire dir,
   input  wire latch,
   input  wire drain,
   input  wire ser_drive,
   input  wire ser_out,
   input  wire ser_input,
   output reg  pin_o,
   output reg  pin_oe
);
   reg val;
   reg en;

   always @* begin
      if (ser_input) begin
         val = 1'b0;
         en  = 1'b0;
      end else if (ser_drive) begin
         val = ser_out;
         en  = 1'b1;
      end else begin
         val = latch;
         en  = dir;
      end
   end

   always @(posedge clk) begin
      if (reset || clear) begin
         pin_o  <= 1'b0;
         pin_oe <= 1'b0;
      end else if (drain) begin
         // high side off: only pull low, release for a one
         pin_o  <= 1'b0;
         pin_oe <= en & ~val;
      end else begin
         pin_o  <= val;
         pin_oe <= en;
      end
   end
endmodule // sio_pin_cell

// [hdl/sio_port.v]
// six-bit i/o port with open-drain select, shared serial pins, axi4-lite registers
//
// Notes on behaviour
// - six bidirectional pins, controlled by bits 5..0 of 8-bit registers.
// - pins behave the same whatever chip operating mode is chosen.
// - pins are shared with transmit, receive and clock of two serial channels.
// - direction register is write-only; reads are undefined; bits 7,6 reserved.
// - direction bit 1 drives the pin as output, 0 makes it input.
// - direction cleared by power-on reset and hardware standby, kept otherwise.
// - output latch is read/write and its value is driven on output pins.
// - latch cleared by power-on reset and hardware standby, kept otherwise.
// - bits 7,6 of latch, level and drain registers read undetermined, ignore writes.
// - pin-level read of an output pin returns the latch bit.
// - pin-level read of an input pin returns the external pin level.
// - pin-level kept through manual reset and software standby.
// - drain bit 1 gives open-drain output, 0 gives push-pull.
// - drain select cleared by power-on reset and hardware standby, kept otherwise.
// - serial initialisation hands shared pins back to direction and latch.
// - drain select applies to serial transmit and clock outputs too.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "sio_map.vh"

module sio_port #(
   parameter AW = 18
) (
   input  wire                    clk,
   input  wire                    reset,
   input  wire                    hw_standby_n,
   input  wire                    manual_reset,
   input  wire                    sw_standby,
   // axi4-lite slave
   input  wire [AW-1:0]           s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output reg                     s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output reg                     s_axi_wready,
   output reg  [1:0]              s_axi_bresp,
   output reg                     s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [AW-1:0]           s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output reg                     s_axi_arready,
   output reg  [31:0]             s_axi_rdata,
   output reg  [1:0]              s_axi_rresp,
   output reg                     s_axi_rvalid,
   input  wire                    s_axi_rready,
   // serial channels
   input  wire                    serial_init,
   input  wire [`SIO_CHANNELS-1:0] ser_tx_en,
   input  wire [`SIO_CHANNELS-1:0] ser_tx_data,
   input  wire [`SIO_CHANNELS-1:0] ser_rx_en,
   output reg  [`SIO_CHANNELS-1:0] ser_rx_data,
   input  wire [`SIO_CHANNELS-1:0] ser_clk_oe,
   input  wire [`SIO_CHANNELS-1:0] ser_clk_out,
   input  wire [`SIO_CHANNELS-1:0] ser_clk_ie,
   output reg  [`SIO_CHANNELS-1:0] ser_clk_in,
   // board pins
   input  wire [`SIO_PORT_W-1:0]  pin_i,
   output wire [`SIO_PORT_W-1:0]  pin_o,
   output wire [`SIO_PORT_W-1:0]  pin_oe
);
   localparam [`SIO_IDX_W-1:0] IDX_DIR   = `SIO_IDX_PIN_DIRECTION;
   localparam [`SIO_IDX_W-1:0] IDX_LEVEL = `SIO_IDX_PIN_LEVEL;
   localparam [`SIO_IDX_W-1:0] IDX_LATCH = `SIO_IDX_OUTPUT_LATCH;
   localparam [`SIO_IDX_W-1:0] IDX_DRAIN = `SIO_IDX_DRAIN_SELECT;

   // registers, bit n belongs to pin n
   reg  [`SIO_PORT_W-1:0] pin_direction_r;
   reg  [`SIO_PORT_W-1:0] output_latch_r;
   reg  [`SIO_PORT_W-1:0] drain_select_r;
   reg  [`SIO_PORT_W-1:0] pin_level_r;
   reg  [`SIO_PORT_W-1:0] pin_level_nxt;

   wire [`SIO_PORT_W-1:0] pin_sync;
   wire [0:0]             stby_sync_n;
   wire                   hw_clear;
   wire                   hold;

   // write channel state
   reg                    aw_got_r;
   reg  [AW-1:0]          aw_addr_r;
   reg                    w_got_r;
   reg  [`SIO_REG_W-1:0]  w_data_r;
   reg                    w_lane_r;
   reg  [AW-1:0]          wr_addr;
   reg  [`SIO_REG_W-1:0]  wr_data;
   reg                    wr_lane;
   reg                    wr_do;
   reg                    wr_hit;
   reg  [`SIO_IDX_W-1:0]  wr_idx;

   // read channel state
   reg  [`SIO_IDX_W-1:0]  rd_idx;
   reg  [`SIO_REG_W-1:0]  rd_val;
   reg                    rd_hit;
   wire                   rd_take;

   // serial steering per pin
   reg  [`SIO_PORT_W-1:0] ser_drive;
   reg  [`SIO_PORT_W-1:0] ser_out;
   reg  [`SIO_PORT_W-1:0] ser_input;

   // the standby pin arrives from the board
   sio_sync #(
      .W (1)
   ) u_stby_sync (
      .clk   (clk),
      .reset (reset),
      .d     (hw_standby_n),
      .q     (stby_sync_n)
   );

   sio_sync #(
      .W (`SIO_PORT_W)
   ) u_pin_sync (
      .clk   (clk),
      .reset (reset),
      .d     (pin_i),
      .q     (pin_sync)
   );

   // synchroniser resets low and shows the pin only two clocks after release
   reg  [1:0]             stby_seen_r;
   always @(posedge clk) begin
      if (reset) begin
         stby_seen_r <= 2'h0;
      end else begin
         stby_seen_r <= {stby_seen_r[0], 1'b1};
      end
   end

   assign hw_clear = stby_seen_r[1] & ~stby_sync_n[0];
   // no mode input exists: behaviour never depends on chip mode
   assign hold     = manual_reset | sw_standby;

   // ---------------------------------------------------------------
   // axi4-lite write side: address and data taken in either order
   // ---------------------------------------------------------------
   always @* begin
      wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
      wr_data = w_got_r ? w_data_r : s_axi_wdata[`SIO_REG_W-1:0];
      wr_lane = w_got_r ? w_lane_r : s_axi_wstrb[0];
      wr_do   = (aw_got_r | (s_axi_awvalid & s_axi_awready)) &
                (w_got_r | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
      wr_idx  = wr_addr[`SIO_IDX_W+1:2];
      wr_hit  = (wr_idx == IDX_DIR) | (wr_idx == IDX_LATCH) |
                (wr_idx == IDX_DRAIN) | (wr_idx == IDX_LEVEL);
   end

   always @(posedge clk) begin
      if (reset || manual_reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SIO_RESP_OKAY;
         aw_got_r      <= 1'b0;
         aw_addr_r     <= {AW{1'b0}};
         w_got_r       <= 1'b0;
         w_data_r      <= {`SIO_REG_W{1'b0}};
         w_lane_r      <= 1'b0;
      end else if (wr_do) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b1;
         s_axi_bresp   <= wr_hit ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r      <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got_r) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r      <= 1'b1;
            w_data_r     <= s_axi_wdata[`SIO_REG_W-1:0];
            w_lane_r     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_got_r) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // port registers
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (reset || hw_clear) begin
         pin_direction_r <= `SIO_RST_PORT;
         output_latch_r  <= `SIO_RST_PORT;
         drain_select_r  <= `SIO_RST_PORT;
      end else if (wr_do && wr_lane) begin
         // manual reset and software standby leave these untouched
         // bits 7 and 6 are simply not stored
         if (wr_idx == IDX_DIR) begin
            pin_direction_r <= wr_data[`SIO_FIELD_MSB:0];
         end
         if (wr_idx == IDX_LATCH) begin
            output_latch_r <= wr_data[`SIO_FIELD_MSB:0];
         end
         if (wr_idx == IDX_DRAIN) begin
            drain_select_r <= wr_data[`SIO_FIELD_MSB:0];
         end
         // a write to the pin-level register is accepted and dropped
      end
   end

   // per bit: output pins show the latch, input pins the pin level
   genvar b;
   generate
      for (b = 0; b < `SIO_PORT_W; b = b + 1) begin : g_level
         always @* begin
            pin_level_nxt[b] = pin_direction_r[b] ? output_latch_r[b]
                                                  : pin_sync[b];
         end
      end
   endgenerate

   // frozen while the chip sits in manual reset or software standby
   always @(posedge clk) begin
      if (reset) begin
         pin_level_r <= `SIO_RST_PORT;
      end else if (!hold) begin
         pin_level_r <= pin_level_nxt;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read side: one read at a time, answer next cycle
   // ---------------------------------------------------------------
   assign rd_take = s_axi_arvalid & s_axi_arready;

   always @* begin
      rd_idx = s_axi_araddr[`SIO_IDX_W+1:2];
      rd_hit = 1'b1;
      rd_val = `SIO_DIR_READ;
      if (rd_idx == IDX_DIR) begin
         rd_val = `SIO_DIR_READ;
      end else if (rd_idx == IDX_LATCH) begin
         rd_val = {`SIO_RESV_READ, output_latch_r};
      end else if (rd_idx == IDX_LEVEL) begin
         rd_val = {`SIO_RESV_READ, pin_level_r};
      end else if (rd_idx == IDX_DRAIN) begin
         rd_val = {`SIO_RESV_READ, drain_select_r};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (reset || manual_reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SIO_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_val};
         s_axi_rresp   <= rd_hit ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // serial channel sharing; init returns pins to port control
   // ---------------------------------------------------------------
   always @* begin
      ser_drive = {`SIO_PORT_W{1'b0}};
      ser_out   = {`SIO_PORT_W{1'b0}};
      ser_input = {`SIO_PORT_W{1'b0}};
      if (!serial_init) begin
         ser_drive[`SIO_PIN_TX0]  = ser_tx_en[0];
         ser_out[`SIO_PIN_TX0]    = ser_tx_data[0];
         ser_drive[`SIO_PIN_TX1]  = ser_tx_en[1];
         ser_out[`SIO_PIN_TX1]    = ser_tx_data[1];
         ser_input[`SIO_PIN_RX0]  = ser_rx_en[0];
         ser_input[`SIO_PIN_RX1]  = ser_rx_en[1];
         // an output clock wins over an input clock request
         ser_drive[`SIO_PIN_CLK0] = ser_clk_oe[0];
         ser_out[`SIO_PIN_CLK0]   = ser_clk_out[0];
         ser_input[`SIO_PIN_CLK0] = ser_clk_ie[0] & ~ser_clk_oe[0];
         ser_drive[`SIO_PIN_CLK1] = ser_clk_oe[1];
         ser_out[`SIO_PIN_CLK1]   = ser_clk_out[1];
         ser_input[`SIO_PIN_CLK1] = ser_clk_ie[1] & ~ser_clk_oe[1];
      end
   end

   // receivers and external clocks see the synchronised pin levels
   always @(posedge clk) begin
      if (reset) begin
         ser_rx_data <= {`SIO_CHANNELS{1'b0}};
         ser_clk_in  <= {`SIO_CHANNELS{1'b0}};
      end else begin
         ser_rx_data <= {pin_sync[`SIO_PIN_RX1], pin_sync[`SIO_PIN_RX0]};
         ser_clk_in  <= {pin_sync[`SIO_PIN_CLK1], pin_sync[`SIO_PIN_CLK0]};
      end
   end

   // one drive stage per pin; drain select covers serial outputs too
   genvar p;
   generate
      for (p = 0; p < `SIO_PORT_W; p = p + 1) begin : g_pin
         sio_pin_cell u_cell (
            .clk       (clk),
            .reset     (reset),
            .clear     (hw_clear),
            .dir       (pin_direction_r[p]),
            .latch     (output_latch_r[p]),
            .drain     (drain_select_r[p]),
            .ser_drive (ser_drive[p]),
            .ser_out   (ser_out[p]),
            .ser_input (ser_input[p]),
            .pin_o     (pin_o[p]),
            .pin_oe    (pin_oe[p])
         );
      end
   endgenerate
endmodule // sio_port

// [verif/sio_board.sv]
// board side of the port: pull-up on every pin plus an external driver
module sio_board (
   input  logic [5:0] pin_o,
   input  logic [5:0] pin_oe,
   input  logic [5:0] ext_en,
   input  logic [5:0] ext_val,
   output logic [5:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // released pins float up unless the external driver is on, so a stale driven level never lingers
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & (~ext_en | ext_val));
endmodule // sio_board

// [verif/sio_port_asserts.sv]
// concurrent checks on the port's bus handshakes and pin drive
module sio_port_asserts (
   input logic        clk,
   input logic        reset,
   input logic        hw_standby_n,
   input logic        serial_init,
   input logic [1:0]  ser_tx_en,
   input logic [1:0]  ser_tx_data,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [5:0]  pin_o,
   input logic [5:0]  pin_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // a released open-drain pin reads as the pull-up level
   wire tx0_lvl = pin_oe[0] ? pin_o[0] : 1'b1;

   chk_reset_idle: assert property ($fell(reset) |->
      !s_axi_bvalid && !s_axi_rvalid && pin_oe == 6'h00) else $error("not idle after reset");
   chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
   chk_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
      else $error("upper read bits set");
   chk_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answering");
   chk_tx_wire: assert property ((ser_tx_en[0] && !serial_init && hw_standby_n
      && $stable(ser_tx_data[0]))[*6] |-> tx0_lvl == ser_tx_data[0])
      else $error("transmit level wrong on pin 0");
   chk_stby_drive: assert property (!hw_standby_n[*5] |-> pin_oe == 6'h00)
      else $error("pin driven in hardware standby");
endmodule // sio_port_asserts

bind sio_port sio_port_asserts u_chk (.*);

// [verif/tb.sv]
// self-checking bench for the six-bit port
`include "sio_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [17:0] A_DIR = {`SIO_IDX_PIN_DIRECTION, 2'b00};
   localparam [17:0] A_LVL = {`SIO_IDX_PIN_LEVEL, 2'b00};
   localparam [17:0] A_LAT = {`SIO_IDX_OUTPUT_LATCH, 2'b00};
   localparam [17:0] A_ODR = {`SIO_IDX_DRAIN_SELECT, 2'b00};
   localparam [1:0]  OK    = `SIO_RESP_OKAY;
   localparam [1:0]  ERR   = `SIO_RESP_SLVERR;
   logic        clk, reset, hw_standby_n, manual_reset, sw_standby, serial_init;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ser_tx_en, ser_tx_data, ser_rx_data, ser_clk_in;
   logic [1:0]  ser_rx_en, ser_clk_oe, ser_clk_out, ser_clk_ie;
   logic [5:0]  pin_i, pin_o, pin_oe, ext_en, ext_val, v;
   logic [7:0]  d, l, od;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          fail_count, compares;

   sio_port dut (
      .clk, .reset, .hw_standby_n, .manual_reset, .sw_standby,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .serial_init, .ser_tx_en, .ser_tx_data,
      .ser_rx_en, .ser_rx_data, .ser_clk_oe, .ser_clk_out,
      .ser_clk_ie, .ser_clk_in, .pin_i, .pin_o, .pin_oe
   );
   sio_board board (.pin_o, .pin_oe, .ext_en, .ext_val, .pin_i);

   task chk(input [33:0] got, input [33:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input [17:0] a, input [31:0] dat, input [3:0] s, input [1:0] r);
      logic ta, tw;
      ta = 0;
      tw = 0;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
         ta |= s_axi_awready;
         tw |= s_axi_wready;
      end
      // a slow response taker keeps the answer standing
      repeat ($urandom % 3) @(posedge clk);
      s_axi_bready <= 1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask

   task rd(input [17:0] a, input [33:0] e);
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      repeat ($urandom % 3) @(posedge clk);
      s_axi_rready <= 1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask

   task pins(input [5:0] dd, input [5:0] ll, input [5:0] oo);
      repeat (2) @(posedge clk);
      chk(pin_oe, dd & ~(oo & ll));
      chk(pin_o & dd, dd & ll & ~oo);
   endtask

   task print_verdict;
      $display("checks %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   initial begin
      #200000;
      fail_count++;
      print_verdict;
   end

   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk(34'(s_axi_bresp), 34'(bq.pop_front()));
   end

   initial begin
      {reset, hw_standby_n, ext_en} = 8'hff;
      {manual_reset, sw_standby, serial_init, ser_tx_en, ser_tx_data, ext_val} = 0;
      {ser_rx_en, ser_clk_oe, ser_clk_out, ser_clk_ie} = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
      repeat (5) @(posedge clk);
      reset <= 0;
      repeat (2) @(posedge clk);
      ext_val <= 6'($urandom(34715));
      repeat (5) @(posedge clk);
      rd(A_LAT, {OK, 32'h0});
      rd(A_ODR, {OK, 32'h0});
      rd(A_DIR, {OK, 32'h0});
      rd(A_LVL, {OK, 26'h0, ext_val});
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         l = 8'($urandom);
         od = 8'($urandom);
         wr(A_DIR, {24'h0, d}, 4'hf, OK);
         wr(A_LAT, {24'h0, l}, 4'hf, OK);
         wr(A_ODR, {24'h0, od}, 4'hf, OK);
         ext_en <= ~d[5:0];
         ext_val <= 6'($urandom);
         pins(d[5:0], l[5:0], od[5:0]);
         repeat (3) @(posedge clk);
         rd(A_LAT, {OK, 26'h0, l[5:0]});
         rd(A_ODR, {OK, 26'h0, od[5:0]});
         rd(A_LVL, {OK, 26'h0, d[5:0] & l[5:0] | ~d[5:0] & ext_val});
      end
      wr(A_LVL, 32'h3f, 4'hf, OK);
      wr(A_LAT, {24'h0, ~l}, 4'h0, OK);
      wr(A_LAT + 18'h4, 32'h1, 4'hf, ERR);
      rd(A_LAT, {OK, 26'h0, l[5:0]});
      wr(A_ODR, 32'h3, 4'hf, OK);
      ser_tx_data <= 2'($urandom);
      ser_tx_en <= 2'b11;
      repeat (7) @(posedge clk);
      chk({pin_o[1:0], pin_oe[1:0]}, {2'b00, ~ser_tx_data});
      serial_init <= 1;
      repeat (3) @(posedge clk);
      chk(pin_oe[1:0], d[1:0] & ~l[1:0]);
      serial_init <= 0;
      ser_tx_en <= 0;
      wr(A_LAT, 32'h2a, 4'hf, OK);
      manual_reset <= 1;
      @(posedge clk);
      manual_reset <= 0;
      @(posedge clk);
      rd(A_LAT, {OK, 32'h2a});
      rd(A_ODR, {OK, 32'h3});
      pins(d[5:0], 6'h2a, 6'h03);
      wr(A_DIR, 32'h0, 4'hf, OK);
      ext_en <= 6'h3f;
      v = 6'($urandom);
      ext_val <= v;
      repeat (5) @(posedge clk);
      sw_standby <= 1;
      ext_val <= ~v;
      repeat (5) @(posedge clk);
      rd(A_LVL, {OK, 26'h0, v});
      sw_standby <= 0;
      wr(A_DIR, 32'h3f, 4'hf, OK);
      hw_standby_n <= 0;
      repeat (8) @(posedge clk);
      hw_standby_n <= 1;
      repeat (6) @(posedge clk);
      chk(pin_oe, 6'h00);
      rd(A_LAT, {OK, 32'h0});
      rd(A_ODR, {OK, 32'h0});
      rd(A_LVL, {OK, 26'h0, ext_val});
      // receive and clock-input pins turn to inputs even when set as outputs
      wr(A_DIR, 32'h3f, 4'hf, OK);
      ser_rx_en <= 2'b11;
      ser_clk_ie <= 2'b11;
      ser_clk_out <= 2'($urandom);
      ext_val <= 6'($urandom);
      repeat (5) @(posedge clk);
      chk(pin_oe, 6'h03);
      chk({ser_clk_in, ser_rx_data}, ext_val[5:2]);
      // a driven serial clock beats a clock input request
      ser_clk_oe <= 2'b11;
      repeat (3) @(posedge clk);
      chk({pin_oe[5:4], pin_o[5:4]}, {2'b11, ser_clk_out});
      print_verdict;
   end
endmodule // tb
